// file: rtl/iopm_pin.sv
`timescale 1ns/100ps
// One pin driver: output mux and enable
module iopm_pin
    import iopm_pkg::*;
(
    input wire logic dout, // Data out register bit
    input wire logic dir, // Direction bit
    input wire logic ctl, // Mode control bit
    input wire logic has_oe_pt, // Port ORs array enable term
    input wire logic pt_oe, // Array enable product term
    input wire logic pld_sel, // Pin owned by logic array
    input wire logic pld_out, // Output macrocell value
    input wire logic addr_bit, // Latched address bit
    input wire logic fixed_sel, // Data or peripheral or scan use
    input wire logic fixed_out, // Value for fixed use
    input wire logic fixed_oe, // Enable for fixed use
    output logic pin_o, // Pin output value
    output logic pin_oe // Pin output enable
);
    logic en;
    assign en = dir | (has_oe_pt & pt_oe);
    // Priority: fixed modes, logic array, address out, host I/O
    always_comb begin
        pin_o = dout;
        pin_oe = en;
        if (fixed_sel) begin
            pin_o = fixed_out;
            pin_oe = fixed_oe;
        end else if (pld_sel) begin
            pin_o = pld_out;
            pin_oe = en;
        end else if (ctl) begin
            pin_o = addr_bit;
            pin_oe = pt_oe | (dir & ctl);
        end else begin
            pin_o = dout;
            pin_oe = en;
        end
    end
endmodule : iopm_pin

// file: rtl/iopm_pkg.sv
package iopm_pkg;
    // Port count and width
    localparam int NPORT = 7;
    localparam int PW = 8;
    // Port indices
    localparam int P_A = 0;
    localparam int P_B = 1;
    localparam int P_C = 2;
    localparam int P_D = 3;
    localparam int P_E = 4;
    localparam int P_F = 5;
    localparam int P_G = 6;
    // Register kinds: index = kind * 8 + port, byte address = index * 4
    localparam logic [2:0] K_DIN = 3'h0;
    localparam logic [2:0] K_DOUT = 3'h1;
    localparam logic [2:0] K_DIR = 3'h2;
    localparam logic [2:0] K_CTL = 3'h3;
    localparam logic [2:0] K_MISC = 3'h4;
    // Misc register slots (port field)
    localparam logic [2:0] M_MAP = 3'h0;
    localparam logic [2:0] M_SPACE = 3'h1;
    // Peripheral enable bit of the memory mapping register
    localparam int MAP_PIO_BIT = 7;
    // Space enable bit of the io space register
    localparam int SPACE_EN_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // Port D has four pins
    localparam logic [7:0] PORTD_MASK = 8'h0F;
    // Nibble width
    localparam int NIB = 4;
endpackage : iopm_pkg

// file: rtl/iopm_top.sv
`timescale 1ns/100ps
// Operation
// - fixed modes from config and pins, only peripheral mode host-writable
// - control bit zero gives host I/O
// - host I/O drives data out, reads pins
// - ports A-C host I/O unless configured
// - array term or direction enables output
// - address out needs enable or dir+ctl
// - address nibbles mapped onto E, F, G
// - address out only on E, F, G
// - enable is direction OR product term on A, B, C, F
// - address inputs feed arrays, strobe latch
// - decode inputs treated as address inputs
// - data port disables general I/O
// - data port chosen by host bus type
// - scan pins on any enable method
// - host I/O direction follows bit/term
// - registers decoded at fixed offsets
// - direction one output, reset input
// - control zero host I/O, default
// - peripheral mode by mapping bit seven
// - peripheral buffer off without select
module iopm_top
    import iopm_pkg::*;
#(
    parameter logic [PW-1:0] CFG_PLD_A = 8'h00, // Array-owned pins, A
    parameter logic [PW-1:0] CFG_PLD_B = 8'h00, // Array-owned pins, B
    parameter logic [PW-1:0] CFG_PLD_C = 8'h00, // Array-owned pins, C
    parameter logic [PW-1:0] CFG_PLD_D = 8'h00, // Array-owned pins, D
    parameter logic [PW-1:0] CFG_PLD_F = 8'h00, // Array-owned pins, F
    parameter logic CFG_NONMUX = 1'b0, // Host bus is non-multiplexed
    parameter logic CFG_ALT_G = 1'b0, // Port G carries address 7..0
    parameter logic CFG_SKIP_LOW = 1'b0, // No low nibble on E, F
    parameter logic CFG_RSTPAT_EN = 1'b0, // Drive reset pattern on the F, G data port
    parameter logic [15:0] CFG_RSTPAT = 16'h0000, // Reset pattern
    parameter logic CFG_IMC_LATCH = 1'b0 // Latch address in on strobe
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, low
    // Avalon-MM slave
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    // Pins, seven ports of eight
    input wire logic [NPORT*PW-1:0] pin_i, // Pin levels
    output logic [NPORT*PW-1:0] pin_o, // Pin drive values
    output logic [NPORT*PW-1:0] pin_oe, // Pin drive enables
    // Logic array side
    input wire logic [NPORT*PW-1:0] pld_out, // Output macrocell values
    input wire logic [NPORT*PW-1:0] pld_oe, // Enable product terms
    output logic [NPORT*PW-1:0] pld_in, // Pin inputs to arrays
    // Host bus side
    input wire logic address_latch_strobe, // Address strobe pin
    input wire logic [15:0] host_addr, // Host address for latching
    input wire logic [15:0] host_data_o, // Host data to drive out
    input wire logic host_data_oe, // Device drives data bus
    output logic [15:0] host_data_i, // Data bus as seen at F, G
    input wire logic peripheral_select_zero, // Peripheral select 0
    input wire logic peripheral_select_one, // Peripheral select 1
    input wire logic [7:0] periph_data_o, // Peripheral data out
    input wire logic periph_dir_out, // Peripheral buffer to pins
    input wire logic in_reset, // Host reset phase active
    input wire logic [2:0] scan_en_src // Scan enable methods
);
    // Register storage
    logic [PW-1:0] dout_r [NPORT]; // Data out
    logic [PW-1:0] dir_r [NPORT]; // Direction
    logic [PW-1:0] ctl_r [NPORT]; // Mode control, E-G used
    logic [7:0] map_r; // Memory mapping register
    logic space_en_r; // I/O register space enabled
    logic [15:0] addr_lat_r; // Latched host address
    logic [PW-1:0] sync1_r [NPORT]; // Pin sync stage one
    logic [PW-1:0] sync2_r [NPORT]; // Pin sync stage two
    logic [PW-1:0] imc_r [NPORT]; // Input macrocell latch
    logic [1:0] als_sync_r; // Strobe synchroniser
    logic als_d_r; // Strobe history
    logic ack_r; // Answer pulse
    logic [31:0] rdata_r; // Read data
    logic [PW-1:0] cfg_pld [NPORT]; // Array ownership per port

    // Decode of address fields
    logic [2:0] a_kind;
    logic [2:0] a_port;
    logic req;
    assign a_kind = avs_address[7:5];
    assign a_port = avs_address[4:2];
    assign req = avs_read | avs_write;

    assign cfg_pld[P_A] = CFG_PLD_A;
    assign cfg_pld[P_B] = CFG_PLD_B;
    assign cfg_pld[P_C] = CFG_PLD_C;
    assign cfg_pld[P_D] = CFG_PLD_D;
    assign cfg_pld[P_E] = RST_BYTE;
    assign cfg_pld[P_F] = CFG_PLD_F;
    assign cfg_pld[P_G] = RST_BYTE;

    // One wait cycle per access: answer the cycle after the request
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;

    // Answer pulse; one cycle so back-to-back requests alternate.
    // A held request must not be taken twice, so the pulse clears
    // itself and every access pays exactly one wait cycle.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Writable register decode: only kinds and ports that exist
    function automatic logic wr_ok(input logic [2:0] k, input logic [2:0] p);
        logic ok;
        ok = 1'b0;
        if (k == K_DOUT || k == K_DIR) begin
            ok = (p < 3'(NPORT));
        end else if (k == K_CTL) begin
            // only E, F, G have control bits
            ok = (p >= 3'(P_E)) && (p < 3'(NPORT));
        end else if (k == K_MISC) begin
            ok = (p == M_MAP) || (p == M_SPACE);
        end
        return ok;
    endfunction : wr_ok

    logic wr_go;
    logic [PW-1:0] wbyte;
    // Registers take the write on the accepting edge
    // Lanes one to three carry nothing; only lane zero can land
    assign wr_go = avs_write & ack_r & avs_byteenable[0];
    assign wbyte = avs_writedata[PW-1:0];

    // Port register writes; visible from next cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NPORT; i++) begin
                dout_r[i] <= RST_BYTE;
                dir_r[i] <= RST_BYTE;
                ctl_r[i] <= RST_BYTE;
            end
        end else if (wr_go && wr_ok(a_kind, a_port) && space_en_r) begin
            // port registers decoded at fixed offsets
            if (a_kind == K_DOUT) begin
                dout_r[a_port] <= wbyte;
            end
            if (a_kind == K_DIR) begin
                // Port D has only four pins
                dir_r[a_port] <= (a_port == 3'(P_D)) ?
                    (wbyte & PORTD_MASK) : wbyte;
            end
            // control bits changeable at run time
            if (a_kind == K_CTL) begin
                ctl_r[a_port] <= wbyte;
            end
        end
    end

    // Mapping and space registers are always reachable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            map_r <= RST_BYTE;
            space_en_r <= 1'b0;
        end else if (wr_go && a_kind == K_MISC) begin
            if (a_port == M_MAP) begin
                map_r <= wbyte;
            end
            if (a_port == M_SPACE) begin
                space_en_r <= wbyte[SPACE_EN_BIT];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    // Captured on the edge that ends the wait cycle, so the data stands while the
    // master samples it and holds until the next read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= RD_ZERO;
        end else if (avs_read && !ack_r) begin
            rdata_r <= RD_ZERO;
            if (a_kind == K_MISC && a_port == M_MAP) begin
                rdata_r[PW-1:0] <= map_r;
            end else if (a_kind == K_MISC && a_port == M_SPACE) begin
                rdata_r[SPACE_EN_BIT] <= space_en_r;
            end else if (space_en_r && a_port < 3'(NPORT)) begin
                unique case (a_kind)
                    K_DIN: rdata_r[PW-1:0] <= sync2_r[a_port];
                    K_DOUT: rdata_r[PW-1:0] <= dout_r[a_port];
                    K_DIR: rdata_r[PW-1:0] <= dir_r[a_port];
                    K_CTL: rdata_r[PW-1:0] <= ctl_r[a_port];
                    default: rdata_r <= RD_ZERO;
                endcase
            end
        end
    end

    // Pin synchronisers, two flops before any use
    // Limitation: a pin level reaches the host two cycles late
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NPORT; i++) begin
                sync1_r[i] <= RST_BYTE;
                sync2_r[i] <= RST_BYTE;
            end
            als_sync_r <= 2'b00;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                sync1_r[i] <= pin_i[i*PW +: PW];
                sync2_r[i] <= sync1_r[i];
            end
            als_sync_r <= {als_sync_r[0], address_latch_strobe};
        end
    end

    // Strobe falling edge latches host address and input macrocells
    // History resets low like the idle strobe, so reset makes no edge
    logic als_fall;
    assign als_fall = als_d_r & ~als_sync_r[1];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            als_d_r <= 1'b0;
            addr_lat_r <= 16'h0000;
            for (int i = 0; i < NPORT; i++) begin
                imc_r[i] <= RST_BYTE;
            end
        end else begin
            als_d_r <= als_sync_r[1];
            if (als_fall) begin
                addr_lat_r <= host_addr;
                for (int i = 0; i < NPORT; i++) begin
                    imc_r[i] <= sync2_r[i];
                end
            end
        end
    end

    // pin inputs to arrays, direct or latched
    // Latching holds the address steady for the whole host cycle
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            pld_in[i*PW +: PW] = CFG_IMC_LATCH ? imc_r[i] : sync2_r[i];
        end
    end

    // Data bus as seen on F (low) and G (high)
    assign host_data_i = {sync2_r[P_G], sync2_r[P_F]};

    // Per-port address and fixed-mode selection
    // Fixed modes come from parameters and pins; only peripheral mode follows a host write (map_r)
    logic [PW-1:0] addr_p [NPORT];
    logic [PW-1:0] fsel [NPORT];
    logic [PW-1:0] fout [NPORT];
    logic [PW-1:0] foe [NPORT];
    logic pio_on;
    logic psel_any;
    logic scan_on;
    // peripheral mode from mapping bit 7
    assign pio_on = map_r[MAP_PIO_BIT];
    // buffer only with a select active
    assign psel_any = peripheral_select_zero | peripheral_select_one;
    assign scan_on = |scan_en_src;

    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            addr_p[i] = RST_BYTE;
            fsel[i] = RST_BYTE;
            fout[i] = RST_BYTE;
            foe[i] = RST_BYTE;
        end
        // address only on E, F, G
        addr_p[P_E] = addr_lat_r[PW-1:0];
        addr_p[P_F] = addr_lat_r[PW-1:0];
        addr_p[P_G] = CFG_ALT_G ? addr_lat_r[PW-1:0] : addr_lat_r[15:PW];
        if (CFG_SKIP_LOW) begin
            // Low nibbles of E, F carry no address here
            addr_p[P_E][NIB-1:0] = dout_r[P_E][NIB-1:0];
            addr_p[P_F][NIB-1:0] = dout_r[P_F][NIB-1:0];
        end
        // non-multiplexed host makes F, G a data port
        if (CFG_NONMUX) begin
            fsel[P_F] = '1;
            fsel[P_G] = '1;
            fout[P_F] = host_data_o[PW-1:0];
            fout[P_G] = host_data_o[15:PW];
            foe[P_F] = {PW{host_data_oe}};
            foe[P_G] = {PW{host_data_oe}};
            // Reset pattern while host in reset, no bus cycle
            if (CFG_RSTPAT_EN && in_reset && !host_data_oe) begin
                fout[P_F] = CFG_RSTPAT[PW-1:0];
                fout[P_G] = CFG_RSTPAT[15:PW];
                foe[P_F] = '1;
                foe[P_G] = '1;
            end
        end else if (pio_on) begin
            fsel[P_F] = '1;
            fout[P_F] = periph_data_o;
            foe[P_F] = {PW{psel_any & periph_dir_out}};
        end
        // Scan pins take the low four pins of E
        if (scan_on) begin
            fsel[P_E][NIB-1:0] = '1;
        end
    end

    // One pin driver per pin
    // Ports A-D never see a control bit, so they never carry address out
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        for (genvar b = 0; b < PW; b++) begin : g_bit
            localparam int K = p * PW + b;
            // term ORed on A, B, C, F only
            localparam logic HAS_PT = (p == P_A) || (p == P_B) ||
                (p == P_C) || (p == P_F);
            iopm_pin u_pin (
                .dout(dout_r[p][b]),
                .dir(dir_r[p][b]),
                .ctl(ctl_r[p][b] & (p >= P_E)),
                .has_oe_pt(HAS_PT),
                .pt_oe(pld_oe[K]),
                .pld_sel(cfg_pld[p][b]),
                .pld_out(pld_out[K]),
                .addr_bit(addr_p[p][b]),
                .fixed_sel(fsel[p][b]),
                .fixed_out(fout[p][b]),
                .fixed_oe(foe[p][b]),
                .pin_o(pin_o[K]),
                .pin_oe(pin_oe[K])
            );
        end
    end
endmodule : iopm_top

// file: tb/iopm_host_model.sv
`timescale 1ns/100ps
// Host side of a multiplexed bus: one address cycle per go
module iopm_host_model (
    input wire logic clk_sys, // Clock
    input wire logic go, // Start an address cycle
    input wire logic [15:0] addr, // Address to present
    output logic strobe = 1'b0, // Address strobe
    output logic [15:0] host_addr = 16'h0000 // Address lines
);
    logic [3:0] cnt_r = 4'h0; // Phase of the address cycle
    // Strobe high three cycles; address held well past its fall,
    // then shown inverted so a late latch sees wrong data
    always_ff @(posedge clk_sys) begin
        if (go && cnt_r == 4'h0) begin
            cnt_r <= 4'h1;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r + 4'h1;
        end
        strobe <= (cnt_r >= 4'h1) && (cnt_r < 4'h4);
        host_addr <= (cnt_r >= 4'h1 && cnt_r < 4'hC) ? addr : ~addr;
    end
endmodule : iopm_host_model

// file: tb/iopm_top_asserts.sv
`timescale 1ns/100ps
// Port-level checks on the host bus and the pin drivers
module iopm_top_asserts
    import iopm_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rstn, // Reset, low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic [NPORT*PW-1:0] pin_oe, // Drive enables
    input wire logic [NPORT*PW-1:0] pld_oe, // Array enable terms
    input wire logic [2:0] scan_en_src // Scan enables
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic space_r; // Mirror of the space enable bit
    // Track space enable so refusals can be judged
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            space_r <= 1'b0;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == 8'h84) begin
            space_r <= avs_writedata[0];
        end
    end
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer next cycle");
    a_wait_idle: assert property (
        !avs_read && !avs_write |-> !avs_waitrequest)
        else $error("stall without request");
    a_rd_upper: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper bytes set");
    a_space_refused: assert property (
        avs_read && !avs_waitrequest && !space_r && avs_address < 8'h80
        |-> avs_readdata == 32'h0000_0000)
        else $error("port read before space enable");
    a_ctl_abcd: assert property (
        avs_read && !avs_waitrequest && avs_address[7:4] == 4'h6
        |-> avs_readdata == 32'h0000_0000)
        else $error("control on ports A to D");
    a_dir_takes: assert property (
        avs_write && !avs_waitrequest && space_r && avs_address == 8'h40
        |=> pin_oe[7:0] == ($past(avs_writedata[7:0]) | pld_oe[7:0]))
        else $error("direction write not applied");
    a_oe_term: assert property (
        (pin_oe[23:0] & pld_oe[23:0]) == pld_oe[23:0])
        else $error("enable term not ored");
    a_scan_off: assert property (
        |scan_en_src |-> pin_oe[35:32] == 4'h0)
        else $error("scan pins still driven");
    a_reset_in: assert property (
        disable iff (1'b0) !rstn |-> pin_oe == 56'h00_0000_0000_0000)
        else $error("pin driven in reset");
    cover property (avs_write && !avs_waitrequest && space_r);
    cover property (|scan_en_src);
    cover property (avs_read && !avs_waitrequest && !space_r);
endmodule : iopm_top_asserts

bind iopm_top iopm_top_asserts iopm_top_asserts_inst (.clk_sys(clk_sys),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_oe(pin_oe), .pld_oe(pld_oe), .scan_en_src(scan_en_src));

// file: tb/tb.sv
`timescale 1ns/100ps
module tb
    import iopm_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b1; // Clock and reset
    logic [7:0] avs_address = 8'h00; // Bus request
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1; // Lane 0 only
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    logic [55:0] pin_i = 56'h0, pld_out = 56'h0, pld_oe = 56'h0;
    wire [55:0] pin_o, pin_oe, pld_in;
    logic go = 1'b0; // Host model trigger
    logic [15:0] go_addr = 16'h0000, host_addr, host_data_i;
    wire address_latch_strobe;
    logic sel0 = 1'b0, sel1 = 1'b0, pdir = 1'b0; // Peripheral side
    logic [7:0] pdata = 8'h00;
    logic [2:0] scan_en_src = 3'h0;
    logic [31:0] rd_q[$]; // Expected read data, oldest first
    logic [7:0] dv[7]; // Data out per port
    int mismatches = 0, checked = 0, seed = 32'h0000_48f0;
    iopm_top iopm_top_inst (.clk_sys(clk_sys), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .pld_out(pld_out), .pld_oe(pld_oe),
        .pld_in(pld_in), .address_latch_strobe(address_latch_strobe),
        .host_addr(host_addr), .host_data_o(16'h0000),
        .host_data_oe(1'b0), .host_data_i(host_data_i),
        .peripheral_select_zero(sel0), .peripheral_select_one(sel1),
        .periph_data_o(pdata), .periph_dir_out(pdir), .in_reset(1'b0),
        .scan_en_src(scan_en_src));
    iopm_host_model iopm_host_model_inst (.clk_sys(clk_sys), .go(go),
        .addr(go_addr), .strobe(address_latch_strobe),
        .host_addr(host_addr));
    always #2.5 clk_sys = ~clk_sys;
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_sim;
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // One bus cycle, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h00_0000, d};
        if (!w) rd_q.push_back(exp);
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 40) begin
            n++;
            @(negedge clk_sys);
        end
        if (n == 40) mismatches++;
        @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    function automatic logic [7:0] ra(logic [2:0] k, int p);
        return {k, 3'(p), 2'b00};
    endfunction : ra
    // Read results are matched against the oldest expectation
    always @(negedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk("readdata", 64'(avs_readdata), 64'(rd_q.pop_front()));
        end
    end
    initial begin
        #60000;
        mismatches++;
        end_sim;
    end
    initial begin
        logic [7:0] d, e;
        // Drop reset at time zero so the async branch really runs
        rstn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        pld_oe <= 56'({$random(seed), $random(seed)}) & 56'h00_FF00_00FF_FFFF;
        pld_out <= 56'({$random(seed), $random(seed)});
        pin_i <= 56'({$random(seed), $random(seed)});
        bus(1'b1, ra(K_DIR, P_A), 8'hFF, 32'h0);
        bus(1'b0, ra(K_DIR, P_A), 8'h00, 32'h0); // refused
        bus(1'b1, 8'h84, 8'h01, 32'h0);
        bus(1'b1, ra(K_CTL, P_A), 8'hFF, 32'h0);
        bus(1'b0, ra(K_CTL, P_A), 8'h00, 32'h0); // no control
        bus(1'b0, ra(K_DIN, P_A), 8'h00, 32'(pin_i[7:0])); // pin level
        bus(1'b0, ra(K_DIN, P_G), 8'h00, 32'(pin_i[55:48])); // pin level
        @(negedge clk_sys);
        chk("pld_in", 64'(pld_in), 64'(pin_i)); // array inputs
        chk("host_data_i", 64'(host_data_i), 64'(pin_i[55:40])); // bus
        // no pin is array-owned here, so any direction is legal
        for (int p = 0; p < NPORT; p++) begin
            d = 8'($random(seed));
            dv[p] = 8'($random(seed));
            e = (p == P_D) ? (d & PORTD_MASK) : d;
            bus(1'b1, ra(K_DIR, p), d, 32'h0);
            bus(1'b1, ra(K_DOUT, p), dv[p], 32'h0);
            bus(1'b0, ra(K_DIR, p), 8'h00, 32'(e)); // readback
            bus(1'b0, ra(K_DOUT, p), 8'h00, 32'(dv[p])); // readback
            e = e | pld_oe[p*8+:8];
            @(negedge clk_sys);
            chk("pin_oe", 64'(pin_oe[p*8+:8]), 64'(e)); // or of term
            chk("pin_o", 64'(pin_o[p*8+:8] & e), 64'(dv[p] & e)); // drive
        end
        go_addr <= 16'($random(seed));
        // address out is switched on only after setup
        for (int p = P_E; p <= P_G; p++) begin
            bus(1'b1, ra(K_CTL, p), 8'hFF, 32'h0);
            bus(1'b1, ra(K_DIR, p), 8'hFF, 32'h0);
        end
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("addr_e", 64'(pin_o[39:32]), 64'(go_addr[7:0])); // low byte
        chk("addr_f", 64'(pin_o[47:40]), 64'(go_addr[7:0])); // on F
        chk("addr_g", 64'(pin_o[55:48]), 64'(go_addr[15:8])); // high byte
        chk("addr_oe", 64'(pin_oe[55:32]), 64'h00FF_FFFF); // dir and ctl
        bus(1'b0, ra(K_CTL, P_G), 8'h00, 32'h0000_00FF); // readback
        bus(1'b1, ra(K_CTL, P_E), 8'h00, 32'h0);
        pld_oe <= 56'h0;
        @(negedge clk_sys);
        chk("host_e", 64'(pin_o[39:32]), 64'(dv[P_E])); // back to host
        for (int p = 0; p < 3; p++) begin
            @(posedge clk_sys);
            scan_en_src <= 3'(1 << p);
            @(negedge clk_sys);
            chk("scan_oe", 64'(pin_oe[35:32]), 64'h0); // any method
        end
        @(posedge clk_sys);
        scan_en_src <= 3'h0;
        bus(1'b1, 8'h80, 8'h80, 32'h0);
        @(negedge clk_sys);
        chk("per_off", 64'(pin_oe[47:40]), 64'h0); // no select
        @(posedge clk_sys);
        sel0 <= 1'b1;
        pdir <= 1'b1;
        pdata <= 8'($random(seed));
        @(negedge clk_sys);
        chk("per_oe", 64'(pin_oe[47:40]), 64'hFF); // mapping bit
        chk("per_o", 64'(pin_o[47:40]), 64'(pdata)); // mapping bit
        @(posedge clk_sys);
        sel0 <= 1'b0;
        sel1 <= 1'b1;
        @(negedge clk_sys);
        chk("per_oe1", 64'(pin_oe[47:40]), 64'hFF); // second select
        @(posedge clk_sys);
        sel1 <= 1'b0;
        pdir <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("rst_oe", 64'(pin_oe), 64'h0); // inputs in reset
        @(posedge clk_sys);
        rstn <= 1'b1;
        bus(1'b0, ra(K_DIR, P_A), 8'h00, 32'h0); // space cleared
        end_sim;
    end
endmodule : tb
